// >>> src/tws_top.sv
// Tape write-start and data-acceptance sequencer with AHB-Lite registers
// Operation
// - Write motion sets only with unit, ring, no interrupt, done, no loss, idle or nonstop set.
// - Lockout releases once unit, ring, interrupts and special function are ok.
// - Write motion drives write request and forward request to transport.
// - Transport busy reply while moving holds the busy latch set.
// - No frame is written before write control sets.
// - Load point reply sets load point flag and inhibits short delay.
// - Long delay waits for load point reply to drop, then runs 30 ms.
// - Write control sets when either delay path expires.
// - Write control drops end-of-record clear and opens data acceptance.
// - 1 ms without transfer after clear drops sets lost data, blocks acceptance.
// - Write output register held clear until write control sets.
// - Parity of each 12-bit word checked on data signal strobe.
// - Parity mismatch sets parity error flag; write continues with the data.
// - Register load sets on data, no lockout, unit, no clear, no resync.
// - Register load lifts byte register clear and gates data into it.
// - Write resync sets 0.1 us after register load.
// - Write resync blocks further data acceptance, one byte per cycle.
// - Write resync stops the lost data timer.
// - Write resync keeps the byte register from clearing until frames done.
// - Write resync sets the reply flag, acknowledging the channel.
// - Data signal drop clears reply flag and register load flag.
// - Second frame step 7 clears write resync and the byte register.
`timescale 1ns/100ps
module tws_top
   import tws_pkg::*;
#(
   parameter int unsigned GAP_CYC  = GAP_DELAY_CYC,
   parameter int unsigned LONG_CYC = LONG_DELAY_CYC,
   parameter int unsigned LOST_CYC = LOST_DATA_CYC
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Channel
   input  wire logic              write_sig,
   input  wire logic              data_sig,
   input  wire logic [BYTE_W-1:0] data_in,
   input  wire logic              parity_in,
   output logic                   reply,
   output logic                   parity_error,
   output logic                   lost_data,
   // Transport
   input  wire logic              unit_connected,
   input  wire logic              write_ring_reply,
   input  wire logic              transport_ready,
   input  wire logic              tape_moving_reply,
   input  wire logic              load_point_reply,
   input  wire logic              busy_reply,
   output logic                   write_request,
   output logic                   forward_request,
   // Controller internal
   input  wire logic              pending_interrupt,
   input  wire logic              special_function_done,
   input  wire logic              frame_pass_done,
   output logic [BYTE_W-1:0]      byte_reg,
   output logic                   write_reg_clear,
   output logic                   write_enable
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pin_s;
   logic             write_s;
   logic             data_s;
   logic [BYTE_W-1:0] din_s;
   logic             par_s;
   logic             unit_s;
   logic             ring_s;
   logic             ready_s;
   logic             moving_s;
   logic             lp_s;
   logic             busy_s;

   tws_sync #(.W(PIN_W)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  ({busy_reply, load_point_reply, tape_moving_reply,
                 transport_ready, write_ring_reply, unit_connected,
                 parity_in, data_in, data_sig, write_sig}),
      .pin_out (pin_s)
   );

   assign write_s  = pin_s[0];
   assign data_s   = pin_s[1];
   assign din_s    = pin_s[13:2];
   assign par_s    = pin_s[14];
   assign unit_s   = pin_s[15];
   assign ring_s   = pin_s[16];
   assign ready_s  = pin_s[17];
   assign moving_s = pin_s[18];
   assign lp_s     = pin_s[19];
   assign busy_s   = pin_s[20];

   // ---------------------------------------------------------------
   // State flags
   // ---------------------------------------------------------------
   logic              write_motion_flag_ff;
   logic              write_control_flag_ff;
   logic              write_data_lockout_ff;
   logic              load_point_flag_ff;
   logic              lost_data_flag_ff;
   logic              busy_latch_ff;
   logic              parity_error_flag_ff;
   logic              register_load_flag_ff;
   logic              write_resync_flag_ff;
   logic              reply_flag_ff;
   logic              data_d_ff;
   logic [BYTE_W-1:0] byte_reg_ff;
   logic [1:0]        ctrl_ff;
   logic              gap_done;
   logic              long_done;
   logic              lost_done;
   logic              resync_done;
   logic              end_of_record_clear;
   logic              data_accept_gate;
   logic              load_enable_gate;
   logic              motion_ok;
   logic              lockout_ok;
   logic              data_strobe;
   logic              clr_lost;
   logic              clr_perr;

   assign end_of_record_clear = !write_control_flag_ff;
   assign data_strobe         = data_s & !data_d_ff;

   // Conditions one to four of the write qualification
   assign lockout_ok = write_s & unit_s & ring_s & !pending_interrupt
                       & special_function_done;
   // Full qualification
   assign motion_ok  = lockout_ok & !lost_data_flag_ff
                       & !write_control_flag_ff & ready_s
                       & (!moving_s | ctrl_ff[CTRL_NONSTOP_BIT]);

   assign data_accept_gate = !end_of_record_clear & !lost_data_flag_ff
                             & !write_resync_flag_ff;
   assign load_enable_gate = data_s & !write_data_lockout_ff & unit_s
                             & data_accept_gate;

   // ---------------------------------------------------------------
   // Delay timers
   // ---------------------------------------------------------------
   tws_timer #(.CYCLES(GAP_CYC)) u_gap (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (write_motion_flag_ff & !load_point_flag_ff
                & !write_control_flag_ff),
      .done    (gap_done)
   );

   tws_timer #(.CYCLES(LONG_CYC)) u_long (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (write_motion_flag_ff & load_point_flag_ff & !lp_s
                & !write_control_flag_ff),
      .done    (long_done)
   );

   tws_timer #(.CYCLES(LOST_CYC)) u_lost (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (!end_of_record_clear & !register_load_flag_ff
                & !write_resync_flag_ff & !lost_data_flag_ff
                & write_s),
      .done    (lost_done)
   );

   tws_timer #(.CYCLES(RESYNC_CYC)) u_resync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (register_load_flag_ff & !write_resync_flag_ff),
      .done    (resync_done)
   );

   // ---------------------------------------------------------------
   // Write start
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_motion_flag_ff <= 1'b0;
      end else if (!write_s) begin
         write_motion_flag_ff <= 1'b0;
      end else if (motion_ok) begin
         write_motion_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_data_lockout_ff <= 1'b1;
      end else if (!write_s) begin
         write_data_lockout_ff <= 1'b1;
      end else if (lockout_ok & end_of_record_clear) begin
         write_data_lockout_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_point_flag_ff <= 1'b0;
      end else if (!write_s) begin
         load_point_flag_ff <= 1'b0;
      end else if (lp_s & !write_motion_flag_ff) begin
         load_point_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_control_flag_ff <= 1'b0;
      end else if (!write_s) begin
         write_control_flag_ff <= 1'b0;
      end else if (gap_done | long_done) begin
         write_control_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_latch_ff <= 1'b0;
      end else if (busy_s & write_motion_flag_ff) begin
         busy_latch_ff <= 1'b1;
      end else if (!write_s) begin
         busy_latch_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Error flags: a new event beats a software clear
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lost_data_flag_ff <= 1'b0;
      end else if (lost_done) begin
         lost_data_flag_ff <= 1'b1;
      end else if (clr_lost) begin
         lost_data_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         parity_error_flag_ff <= 1'b0;
      end else if (data_strobe & write_s
                   & ((^{din_s, par_s}) == ctrl_ff[CTRL_BCD_BIT])) begin
         parity_error_flag_ff <= 1'b1;
      end else if (clr_perr) begin
         parity_error_flag_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Data acceptance
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_d_ff <= 1'b0;
      end else begin
         data_d_ff <= data_s;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         register_load_flag_ff <= 1'b0;
      end else if (!data_s) begin
         register_load_flag_ff <= 1'b0;
      end else if (load_enable_gate) begin
         register_load_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_resync_flag_ff <= 1'b0;
      end else if (resync_done) begin
         write_resync_flag_ff <= 1'b1;
      end else if (frame_pass_done | !write_control_flag_ff) begin
         write_resync_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reply_flag_ff <= 1'b0;
      end else if (!data_s) begin
         reply_flag_ff <= 1'b0;
      end else if (resync_done) begin
         reply_flag_ff <= 1'b1;
      end
   end

   // Byte register clear held unless loading or resync holds it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_reg_ff <= '0;
      end else if (register_load_flag_ff & !write_resync_flag_ff) begin
         byte_reg_ff <= din_s;
      end else if (write_resync_flag_ff & !frame_pass_done) begin
         byte_reg_ff <= byte_reg_ff;
      end else begin
         byte_reg_ff <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Flopped outputs
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_request   <= 1'b0;
         forward_request <= 1'b0;
         write_reg_clear <= 1'b1;
         write_enable    <= 1'b0;
         reply           <= 1'b0;
         parity_error    <= 1'b0;
         lost_data       <= 1'b0;
         byte_reg        <= '0;
      end else begin
         write_request   <= write_motion_flag_ff & write_s;
         forward_request <= write_motion_flag_ff & write_s;
         write_reg_clear <= end_of_record_clear;
         write_enable    <= write_control_flag_ff;
         reply           <= reply_flag_ff & data_s;
         parity_error    <= parity_error_flag_ff;
         lost_data       <= lost_data_flag_ff;
         byte_reg        <= byte_reg_ff;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic        addr_take;
   logic [31:0] status_word;

   assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
   assign clr_lost  = wr_pend_ff & (wr_addr_ff == CTRL_OFS)
                      & hwdata[CTRL_CLR_LOST_BIT];
   assign clr_perr  = wr_pend_ff & (wr_addr_ff == CTRL_OFS)
                      & hwdata[CTRL_CLR_PERR_BIT];

   always_comb begin
      status_word                 = 32'h0;
      status_word[ST_MOTION_BIT]  = write_motion_flag_ff;
      status_word[ST_CONTROL_BIT] = write_control_flag_ff;
      status_word[ST_LOCKOUT_BIT] = write_data_lockout_ff;
      status_word[ST_LOADPT_BIT]  = load_point_flag_ff;
      status_word[ST_LOST_BIT]    = lost_data_flag_ff;
      status_word[ST_BUSY_BIT]    = busy_latch_ff;
      status_word[ST_PERR_BIT]    = parity_error_flag_ff;
      status_word[ST_REGLOAD_BIT] = register_load_flag_ff;
      status_word[ST_RESYNC_BIT]  = write_resync_flag_ff;
      status_word[ST_REPLY_BIT]   = reply_flag_ff;
   end

   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input logic [1:0] c,
                                          input logic [31:0] s,
                                          input logic [BYTE_W-1:0] b);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         CTRL_OFS:   r = {30'h0, c};
         STATUS_OFS: r = s;
         BYTE_OFS:   r = {20'h0, b};
         default:    r = 32'h0;
      endcase
      return r;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h0;
      end else begin
         wr_pend_ff <= addr_take & hwrite & (haddr[31:8] == 24'h0);
         wr_addr_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_pend_ff & (wr_addr_ff == CTRL_OFS)) begin
         ctrl_ff <= hwdata[1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
         if (addr_take & !hwrite) begin
            hrdata <= (haddr[31:8] == 24'h0)
                      ? rd_mux(haddr[7:0], ctrl_ff, status_word, byte_reg_ff)
                      : 32'h0;
         end
      end
   end
endmodule

// >>> src/tws_pkg.sv
// Package: constants for the tape write-start sequencer
package tws_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned GAP_DELAY_US    = 5000;
   localparam int unsigned LONG_DELAY_MS   = 30;
   localparam int unsigned LOST_DATA_MS    = 1;
   localparam int unsigned RESYNC_DELAY_NS = 100;
   localparam int unsigned GAP_DELAY_CYC   = GAP_DELAY_US * CLK_MHZ;
   localparam int unsigned LONG_DELAY_CYC  = LONG_DELAY_MS * CLK_MHZ * 1000;
   localparam int unsigned LOST_DATA_CYC   = LOST_DATA_MS * CLK_MHZ * 1000;
   localparam int unsigned RESYNC_CYC      =
      (RESYNC_DELAY_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Data path
   // ---------------------------------------------------------------
   localparam int unsigned BYTE_W = 12;
   localparam int unsigned PIN_W  = 21;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] BYTE_OFS   = 8'h08;

   // CTRL fields
   localparam int unsigned CTRL_NONSTOP_BIT   = 0;
   localparam int unsigned CTRL_BCD_BIT       = 1;
   localparam int unsigned CTRL_CLR_LOST_BIT  = 2;
   localparam int unsigned CTRL_CLR_PERR_BIT  = 3;
   localparam logic [1:0]  CTRL_RESET         = 2'h0;

   // STATUS fields
   localparam int unsigned ST_MOTION_BIT   = 0;
   localparam int unsigned ST_CONTROL_BIT  = 1;
   localparam int unsigned ST_LOCKOUT_BIT  = 2;
   localparam int unsigned ST_LOADPT_BIT   = 3;
   localparam int unsigned ST_LOST_BIT     = 4;
   localparam int unsigned ST_BUSY_BIT     = 5;
   localparam int unsigned ST_PERR_BIT     = 6;
   localparam int unsigned ST_REGLOAD_BIT  = 7;
   localparam int unsigned ST_RESYNC_BIT   = 8;
   localparam int unsigned ST_REPLY_BIT    = 9;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// >>> src/tws_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module tws_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Pins and clean copy
   input  wire logic [W-1:0] pin_in,
   output logic [W-1:0]      pin_out
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A bit changes once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_out[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
               pin_out[i] <= s3_ff[i];
            end
         end
      end
   endgenerate
endmodule

// >>> src/tws_timer.sv
// Cycle-count delay timer, restarts whenever run drops
`timescale 1ns/100ps
module tws_timer #(
   parameter int unsigned CYCLES = 1
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control and result
   input  wire logic run,
   output logic      done
);
   logic [31:0] cnt_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 32'h0;
         done   <= 1'b0;
      end else if (!run) begin
         cnt_ff <= 32'h0;
         done   <= 1'b0;
      end else if (!done) begin
         cnt_ff <= cnt_ff + 32'h1;
         done   <= (cnt_ff == 32'(CYCLES - 1));
      end
   end
endmodule

// >>> verification/tws_monitor.sv
// Port checker for the write-start sequencer
`timescale 1ns/100ps
module tws_monitor #(parameter int unsigned GAP_CYC = 20) (
   // Clock and reset
   input wire logic hclk, hresetn,
   // Channel and transport
   input wire logic write_sig, data_sig, reply, lost_data,
   input wire logic write_request, forward_request,
   input wire logic write_reg_clear, write_enable
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_FWD:
      assert property (write_request |-> forward_request) else $error("fwd");
   AST_IDLE:
      assert property (!write_sig [*8] |-> !write_request) else $error("idle");
   AST_GAP:
      assert property ($rose(write_enable) |->
         $past(write_request, GAP_CYC - 4)) else $error("gap early");
   AST_CLR:
      assert property (write_enable [*2] |-> !write_reg_clear)
      else $error("clear held");
   AST_REPLY_CTL:
      assert property (reply |-> write_enable) else $error("reply no ctl");
   AST_REPLY_DATA:
      assert property ($rose(reply) |-> $past(data_sig, 6))
      else $error("reply no data");
   AST_REPLY_HOLD:
      assert property (reply && data_sig |=> reply) else $error("reply drop");
   AST_LOST_BLOCK:
      assert property (lost_data && !reply |=> !reply) else $error("late");
   cover property ($rose(reply));
   cover property ($rose(lost_data));
   cover property ($rose(write_enable));
endmodule
bind tws_top tws_monitor #(.GAP_CYC(GAP_CYC)) tws_monitor_i (.hclk,
   .hresetn, .write_sig, .data_sig, .reply, .lost_data, .write_request,
   .forward_request, .write_reg_clear, .write_enable);

// >>> verification/tws_chan_model.sv
// Channel model: hands over bytes with the data/reply handshake
`timescale 1ns/100ps
module tws_chan_model (
   // Clock and bench control
   input  wire logic        hclk, write_sig, reply, send, par,
   input  wire logic [11:0] word,
   // Channel lines
   output logic             data_sig, parity_in,
   output logic [11:0]      data_in
);
   int unsigned wr_cnt = 0;
   initial {data_sig, parity_in, data_in} = {2'h1, 12'hFFF};
   always @(posedge hclk) wr_cnt <= write_sig ? wr_cnt + 1 : 0;
   always @(posedge hclk) begin
      // Data waits 2 us after write, then holds until the reply
      if (send && !reply && !data_sig && wr_cnt >= 260) begin
         {data_in, parity_in} <= {word, par};
         @(posedge hclk);
         data_sig <= 1'b1;
         do @(posedge hclk); while (reply !== 1'b1);
         data_sig <= 1'b0;
         {data_in, parity_in} <= {~word, ~par};
      end
   end
endmodule

// >>> verification/tws_top_tb_top.sv
// Self-checking bench for the write-start sequencer
`timescale 1ns/100ps
module tws_top_tb_top
   import tws_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hrdy, reply, perr, lost, wreq;
   logic        freq, wclr, wen, wsig, dsig, pin, send, par, unit, fpd;
   logic        ring, rdy, mov, lp, busy, pint;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [11:0] din, word, byt, w;
   logic [12:0] exp_q[$];
   int          err_total = 0, n_compared = 0, k;
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   tws_top #(.GAP_CYC(20), .LONG_CYC(50), .LOST_CYC(400)) tws_top_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata,
      .write_sig(wsig), .data_sig(dsig), .data_in(din), .parity_in(pin),
      .reply, .parity_error(perr), .lost_data(lost), .unit_connected(unit),
      .write_ring_reply(ring), .transport_ready(rdy),
      .tape_moving_reply(mov), .load_point_reply(lp), .busy_reply(busy),
      .write_request(wreq), .forward_request(freq),
      .pending_interrupt(pint), .special_function_done(1'b1),
      .frame_pass_done(fpd), .byte_reg(byt), .write_reg_clear(wclr),
      .write_enable(wen));
   tws_chan_model tws_chan_model_i (.hclk, .write_sig(wsig), .reply, .send,
      .par, .word, .data_sig(dsig), .parity_in(pin), .data_in(din));
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      {hsel, htrans, haddr, hwrite} <= {1'b1, HTRANS_NONSEQ, 24'h0, a, wr};
      do @(posedge hclk); while (hrdy !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task report_and_stop;
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Result checker: compares each acknowledged byte with the oldest note
   always @(posedge reply) begin
      chk(exp_q.size() > 0 && {perr, byt} === exp_q[0], "byte");
      if (exp_q.size() > 0)
         void'(exp_q.pop_front());
   end
   initial begin
      repeat (5000) @(posedge hclk);
      err_total++;
      report_and_stop();
   end
   initial begin
      void'($urandom(80933));
      {hresetn, hsel, hwrite, wsig, send, par, fpd, unit, mov} = '0;
      {lp, busy, pint} = '0;
      {htrans, haddr, hwdata, word} = '0;
      {ring, rdy} = 2'h3;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(wclr === 1'b1 && wen === 1'b0, "reset state");
      wsig <= 1'b1;
      repeat (40) @(posedge hclk);
      chk(wreq === 1'b0, "motion without unit");
      {unit, pint} <= 2'h3;
      repeat (40) @(posedge hclk);
      chk(wreq === 1'b0, "motion with interrupt");
      {pint, busy} <= 2'h1;
      repeat (40) @(posedge hclk);
      chk(wreq === 1'b1 && freq === 1'b1, "motion requests");
      chk(wen === 1'b1 && wclr === 1'b0, "write control");
      // Good parity byte, then a bad one back to back
      for (int i = 0; i < 2; i++) begin
         w = 12'($urandom);
         exp_q.push_back({1'(i), w});
         {word, par, send} <= {w, ~^w ^ 1'(i), 1'b1};
         for (k = 0; k < 500 && reply !== 1'b1; k++) @(posedge hclk);
         chk(reply === 1'b1, "no reply");
         send <= 1'b0;
         for (k = 0; k < 50 && reply !== 1'b0; k++) @(posedge hclk);
         chk(reply === 1'b0, "reply stuck");
         fpd <= 1'b1;
         @(posedge hclk);
         fpd <= 1'b0;
      end
      ahb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[ST_PERR_BIT] === 1'b1, "parity sticky");
      chk(rd[ST_BUSY_BIT] === 1'b1, "busy latch");
      wsig <= 1'b0;
      repeat (20) @(posedge hclk);
      ahb(1'b1, CTRL_OFS, 32'hC);
      ahb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[ST_PERR_BIT] === 1'b0 && wclr === 1'b1, "cleared");
      ahb(1'b0, 8'h40, 32'h0);
      chk(rd === 32'h0, "unmapped read");
      {lp, wsig} <= 2'h3;
      repeat (40) @(posedge hclk);
      chk(wen === 1'b0 && wreq === 1'b1, "gap held at load point");
      lp <= 1'b0;
      repeat (40) @(posedge hclk);
      chk(wen === 1'b0, "long delay early");
      repeat (30) @(posedge hclk);
      chk(wen === 1'b1, "long delay");
      repeat (450) @(posedge hclk);
      chk(lost === 1'b1, "lost data");
      send <= 1'b1;
      repeat (80) @(posedge hclk);
      chk(reply === 1'b0, "late byte taken");
      report_and_stop();
   end
endmodule
